// ==== include/ots_defines.svh ====
`ifndef OTS_DEFINES_SVH
`define OTS_DEFINES_SVH

// register byte offsets
`define OTS_OFF_PIN_MODE     12'h000
`define OTS_OFF_RELAY_SEL    12'h004
`define OTS_OFF_DOUT1_SEL    12'h008
`define OTS_OFF_DOUT2_SEL    12'h00C
`define OTS_OFF_SHARED_SEL   12'h010
`define OTS_OFF_STATUS       12'h014

// reset values
`define OTS_RST_PIN_MODE     8'h02
`define OTS_RST_RELAY_SEL    8'h02
`define OTS_RST_DOUT1_SEL    8'h01
`define OTS_RST_DOUT2_SEL    8'h04
`define OTS_RST_SHARED_SEL   8'h00

// shared pin modes
`define OTS_MODE_PULSE       8'h00
`define OTS_MODE_DIGITAL     8'h01
`define OTS_MODE_ANALOG      8'h02

// function codes
`define OTS_FN_NONE          5'd0
`define OTS_FN_COUNT         23

// timing
`define OTS_CLK_MHZ          200
`define OTS_PULSE_MAX_KHZ    50
`define OTS_PULSE_DIV        (2 * `OTS_PULSE_MAX_KHZ)
`define OTS_PULSE_HALF_MIN   ((`OTS_CLK_MHZ * 1000 + `OTS_PULSE_DIV - 1) / `OTS_PULSE_DIV)
`define OTS_SEQ_PULSE_MS     250
`define OTS_SEQ_PULSE_CYC    (`OTS_SEQ_PULSE_MS * `OTS_CLK_MHZ * 1000)

`endif

// ==== include/ots_pkg.sv ====
package ots_pkg;

   typedef struct packed {
      logic        running;
      logic        braking;
      logic        freq_present;
      logic        out_freq_zero;
      logic        fault_any;
      logic        fault_undervoltage;
      logic        bus_voltage_ok;
      logic        coast_stop_active;
      logic        can_run;
      logic        zero_current;
      logic        motor_overload_warn;
      logic        drive_overload_warn;
      logic        frequency_level_detect;
      logic        freq_reached;
      logic        comm_setting;
      logic        external_brake;
      logic        sw_overcurrent;
      logic        step_sequencer_done;
      logic [15:0] set_freq;
      logic [15:0] run_freq;
      logic [15:0] upper_limit;
      logic [15:0] lower_limit;
      logic [15:0] count_value;
      logic [15:0] set_count_target;
      logic [15:0] designated_count_target;
      logic [15:0] length;
      logic [15:0] length_target;
      logic [31:0] accumulated_run_time;
      logic [31:0] run_time_limit;
      logic signed [15:0] analog_input_one;
      logic signed [15:0] analog_input_two;
      logic [15:0] analog_level;
      logic [31:0] pulse_half_period;
   } ots_core_t;

   typedef struct packed {
      logic        relay;
      logic        digital_out_one;
      logic        digital_out_two;
      logic        multi_function_pin;
      logic        analog_drive_en;
      logic [15:0] analog_output;
   } ots_pins_t;

endpackage : ots_pkg

// ==== logic/ots_top.sv ====
`timescale 1ns/1ps
`include "ots_defines.svh"
module ots_top #(
   parameter int unsigned SEQ_PULSE_CYC = `OTS_SEQ_PULSE_CYC
) (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // drive core status
   input  wire ots_pkg::ots_core_t     core_i,
   // output terminals
   output ots_pkg::ots_pins_t          pins_o
);
   import ots_pkg::*;

   localparam int unsigned HALF_MIN = `OTS_PULSE_HALF_MIN;

   typedef struct packed {
      logic [7:0]       mode;
      logic [3:0][7:0]  sel;
      logic [31:0]      pulse_cnt;
      logic             pulse_lvl;
      logic [31:0]      seq_cnt;
      logic             seq_on;
      ots_pins_t        pins;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } ots_state_t;

   ots_state_t q_r;
   ots_state_t q_nxt;

   // condition vector indexed by function code
   logic [`OTS_FN_COUNT-1:0] cond;
   logic [16:0]              ai1_abs;
   logic [16:0]              ai2_abs;
   logic [3:0]               sel_on;

   always_comb begin
      ai1_abs = core_i.analog_input_one[15] ? 17'(-$signed({core_i.analog_input_one[15],
                 core_i.analog_input_one})) : {1'b0, core_i.analog_input_one};
      ai2_abs = core_i.analog_input_two[15] ? 17'(-$signed({core_i.analog_input_two[15],
                 core_i.analog_input_two})) : {1'b0, core_i.analog_input_two};
      cond     = '0;
      cond[0]  = 1'b0;
      cond[1]  = (core_i.running | core_i.braking) & core_i.freq_present;
      cond[2]  = core_i.fault_any & ~core_i.fault_undervoltage;
      cond[3]  = core_i.frequency_level_detect;
      cond[4]  = core_i.freq_reached;
      cond[5]  = (core_i.set_freq >= core_i.upper_limit) &
                 (core_i.run_freq >= core_i.upper_limit);
      cond[6]  = (core_i.set_freq <= core_i.lower_limit) &
                 (core_i.run_freq <= core_i.lower_limit);
      cond[7]  = (core_i.running & core_i.out_freq_zero) |
                 ~(core_i.running | core_i.braking);
      cond[8]  = core_i.motor_overload_warn;
      cond[9]  = core_i.drive_overload_warn;
      cond[10] = core_i.count_value >= core_i.set_count_target;
      cond[11] = core_i.count_value >= core_i.designated_count_target;
      cond[12] = core_i.length > core_i.length_target;
      cond[13] = q_r.seq_on;
      cond[14] = core_i.accumulated_run_time > core_i.run_time_limit;
      cond[15] = core_i.comm_setting;
      cond[16] = ~core_i.fault_any & core_i.bus_voltage_ok &
                 ~core_i.coast_stop_active & core_i.can_run;
      cond[17] = ai1_abs > ai2_abs;
      cond[18] = core_i.zero_current;
      cond[19] = core_i.external_brake;
      cond[20] = core_i.sw_overcurrent;
      cond[21] = core_i.fault_any;
      cond[22] = core_i.running & core_i.out_freq_zero;
   end

   // codes beyond the table select nothing
   for (genvar i = 0; i < 4; i++) begin : g_sel
      assign sel_on[i] = (q_r.sel[i] < 8'(`OTS_FN_COUNT)) &&
                         cond[q_r.sel[i][4:0]];
   end

   logic        wr_acc;
   logic        rd_acc;
   logic        addr_ok;
   logic [31:0] rd_val;

   always_comb begin
      q_nxt   = q_r;
      addr_ok = 1'b1;
      rd_val  = '0;
      unique case (paddr)
         `OTS_OFF_PIN_MODE:   rd_val = {24'h00_0000, q_r.mode};
         `OTS_OFF_RELAY_SEL:  rd_val = {24'h00_0000, q_r.sel[0]};
         `OTS_OFF_DOUT1_SEL:  rd_val = {24'h00_0000, q_r.sel[1]};
         `OTS_OFF_DOUT2_SEL:  rd_val = {24'h00_0000, q_r.sel[2]};
         `OTS_OFF_SHARED_SEL: rd_val = {24'h00_0000, q_r.sel[3]};
         `OTS_OFF_STATUS:     rd_val = {27'h000_0000, q_r.pins.relay,
                                 q_r.pins.digital_out_one, q_r.pins.digital_out_two,
                                 q_r.pins.multi_function_pin, q_r.pins.analog_drive_en};
         default:             addr_ok = 1'b0;
      endcase
      // one wait state: answer registered at the end of the first access cycle
      // writes land only at the edge where the master sees pready high
      wr_acc = psel & penable & q_r.pready & pwrite;
      rd_acc = psel & penable & ~q_r.pready & ~pwrite;
      q_nxt.pready  = psel & penable & ~q_r.pready;
      q_nxt.pslverr = psel & penable & ~q_r.pready & ~addr_ok;
      if (rd_acc) begin
         q_nxt.prdata = addr_ok ? rd_val : 32'h0000_0000;
      end
      if (wr_acc && pstrb[0]) begin
         unique case (paddr)
            // illegal modes are dropped so the pin never sits in an undefined mode
            `OTS_OFF_PIN_MODE: if (pwdata[7:0] <= `OTS_MODE_ANALOG) begin
               q_nxt.mode = pwdata[7:0];
            end
            `OTS_OFF_RELAY_SEL:  q_nxt.sel[0] = pwdata[7:0];
            `OTS_OFF_DOUT1_SEL:  q_nxt.sel[1] = pwdata[7:0];
            `OTS_OFF_DOUT2_SEL:  q_nxt.sel[2] = pwdata[7:0];
            `OTS_OFF_SHARED_SEL: q_nxt.sel[3] = pwdata[7:0];
            default: ;
         endcase
      end

      // sequencer pulse: a new cycle end restarts the full width
      if (core_i.step_sequencer_done) begin
         q_nxt.seq_cnt = 32'(SEQ_PULSE_CYC - 1);
         q_nxt.seq_on  = 1'b1;
      end else if (q_r.seq_cnt != 32'h0000_0000) begin
         q_nxt.seq_cnt = q_r.seq_cnt - 32'h0000_0001;
      end else begin
         q_nxt.seq_on  = 1'b0;
      end

      // pulse generator, half period clamped to the 50 kHz limit
      if (q_r.mode != `OTS_MODE_PULSE) begin
         q_nxt.pulse_cnt = '0;
         q_nxt.pulse_lvl = 1'b0;
      end else if (q_r.pulse_cnt == 32'h0000_0000) begin
         q_nxt.pulse_lvl = ~q_r.pulse_lvl;
         q_nxt.pulse_cnt = (core_i.pulse_half_period < 32'(HALF_MIN)) ?
                           32'(HALF_MIN - 1) : core_i.pulse_half_period - 32'h0000_0001;
      end else begin
         q_nxt.pulse_cnt = q_r.pulse_cnt - 32'h0000_0001;
      end

      q_nxt.pins.relay           = sel_on[0];
      q_nxt.pins.digital_out_one = sel_on[1];
      q_nxt.pins.digital_out_two = sel_on[2];
      unique case (q_r.mode)
         `OTS_MODE_PULSE:   q_nxt.pins.multi_function_pin = q_r.pulse_lvl;
         `OTS_MODE_DIGITAL: q_nxt.pins.multi_function_pin = sel_on[3];
         default:           q_nxt.pins.multi_function_pin = 1'b0;
      endcase
      q_nxt.pins.analog_drive_en = (q_r.mode == `OTS_MODE_ANALOG);
      q_nxt.pins.analog_output   = (q_r.mode == `OTS_MODE_ANALOG) ?
                                   core_i.analog_level : 16'h0000;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r        <= '0;
         q_r.mode   <= `OTS_RST_PIN_MODE;
         q_r.sel[0] <= `OTS_RST_RELAY_SEL;
         q_r.sel[1] <= `OTS_RST_DOUT1_SEL;
         q_r.sel[2] <= `OTS_RST_DOUT2_SEL;
         q_r.sel[3] <= `OTS_RST_SHARED_SEL;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata  = q_r.prdata;
   assign pready  = q_r.pready;
   assign pslverr = q_r.pslverr;
   assign pins_o  = q_r.pins;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_mode_legal;
      q_r.mode <= `OTS_MODE_ANALOG;
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("pin mode out of range");

   property p_one_function;
      pins_o.analog_drive_en |-> !pins_o.multi_function_pin && $past(q_r.mode) == 8'h02;
   endproperty
   a_one_function: assert property (p_one_function) else $error("shared pin doubly driven");

   property p_pulse_rate;
      $changed(q_r.pulse_lvl) && q_r.mode == `OTS_MODE_PULSE |->
         q_r.pulse_cnt >= 32'(HALF_MIN - 1);
   endproperty
   a_pulse_rate: assert property (p_pulse_rate) else $error("pulse half period too short");

   property p_code0_off;
      $past(q_r.sel[0]) == 8'h00 |-> !pins_o.relay;
   endproperty
   a_code0_off: assert property (p_code0_off) else $error("code 0 output not off");

   property p_run_out;
      $past(q_r.sel[1]) == 8'h01 |->
         pins_o.digital_out_one == $past((core_i.running | core_i.braking) & core_i.freq_present);
   endproperty
   a_run_out: assert property (p_run_out) else $error("running output wrong");

   property p_fault1;
      $past(q_r.sel[0]) == 8'h02 |->
         pins_o.relay == $past(core_i.fault_any & ~core_i.fault_undervoltage);
   endproperty
   a_fault1: assert property (p_fault1) else $error("fault output 1 wrong");

   property p_fault2;
      $past(q_r.sel[2]) == 8'h15 |-> pins_o.digital_out_two == $past(core_i.fault_any);
   endproperty
   a_fault2: assert property (p_fault2) else $error("fault output 2 wrong");

   property p_zero2;
      $past(q_r.sel[2]) == 8'h16 |->
         pins_o.digital_out_two == $past(core_i.running & core_i.out_freq_zero);
   endproperty
   a_zero2: assert property (p_zero2) else $error("zero speed 2 output wrong");

   property p_seq_hold;
      $rose(q_r.seq_on) |-> q_r.seq_on [*8];
   endproperty
   a_seq_hold: assert property (p_seq_hold) else $error("sequencer pulse cut short");

   property p_bad_code;
      $past(q_r.sel[1]) > 8'h16 |-> !pins_o.digital_out_one;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("unsupported code drove output");

   property p_apb_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

   c_pulse_mode: cover property (q_r.mode == `OTS_MODE_PULSE && $rose(pins_o.multi_function_pin));
   c_seq_pulse:  cover property ($rose(q_r.seq_on));
   c_write:      cover property (wr_acc && paddr == `OTS_OFF_RELAY_SEL);
   c_slverr:     cover property (pslverr);

endmodule : ots_top

// ==== tb/ots_load.sv ====
`timescale 1ns/1ps
// far-side load: times the shared pin's pulse train while armed
module ots_load (
   // clock and control
   input  wire logic               core_clk,
   input  wire logic               arm,
   // terminals
   input  wire ots_pkg::ots_pins_t pins,
   // shortest half period seen, first edge ignored as partial
   output int                      min_half
);
   import ots_pkg::*;
   int   run;
   int   nt;
   logic last;
   always @(posedge core_clk) begin
      last <= pins.multi_function_pin;
      if (!arm) begin
         run <= 0;
         nt <= 0;
         min_half <= 1 << 30;
      end else if (pins.multi_function_pin !== last) begin
         if (nt > 0 && run < min_half) min_half <= run;
         nt <= nt + 1;
         run <= 1;
      end else begin
         run <= run + 1;
      end
   end
endmodule : ots_load

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import ots_pkg::*;
   localparam int SEQ = 20;
   logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, arm;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb;
   ots_core_t   core_i;
   ots_pins_t   pins_o;
   int          min_half, num_errors, cmp_count;
   logic [31:0] rstv [6] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0001,
                             32'h0000_0004, 32'h0000_0000, 32'h0000_0001};

   ots_top #(.SEQ_PULSE_CYC(SEQ)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_i(core_i), .pins_o(pins_o));
   ots_load load (.core_clk(core_clk), .arm(arm), .pins(pins_o), .min_half(min_half));

   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      for (int i = 0; i < 32; i++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
      return v;
   endfunction : lfsr

   // behavioural model of one output for a selector code
   function automatic logic exp_fn(input int k, input ots_core_t c);
      int a;
      int b;
      a = c.analog_input_one;
      b = c.analog_input_two;
      case (k)
         1: return (c.running | c.braking) & c.freq_present;
         2: return c.fault_any & !c.fault_undervoltage;
         3: return c.frequency_level_detect;
         4: return c.freq_reached;
         5: return c.set_freq >= c.upper_limit && c.run_freq >= c.upper_limit;
         6: return c.set_freq <= c.lower_limit && c.run_freq <= c.lower_limit;
         7: return (c.running & c.out_freq_zero) | (!c.running & !c.braking);
         8: return c.motor_overload_warn;
         9: return c.drive_overload_warn;
         10: return c.count_value >= c.set_count_target;
         11: return c.count_value >= c.designated_count_target;
         12: return c.length > c.length_target;
         14: return c.accumulated_run_time > c.run_time_limit;
         15: return c.comm_setting;
         16: return !c.fault_any & c.bus_voltage_ok & !c.coast_stop_active & c.can_run;
         17: return ((a < 0) ? -a : a) > ((b < 0) ? -b : b);
         18: return c.zero_current;
         19: return c.external_brake;
         20: return c.sw_overcurrent;
         21: return c.fault_any;
         22: return c.running & c.out_freq_zero;
         default: return 1'b0;
      endcase
   endfunction : exp_fn

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [31:0] d, output logic e);
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1;
      // ends when pready is seen high; if it never comes, only the watchdog ends this wait
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, a, v, 4'hf, d, e);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, 4'hf, d, e);
      chk(d, x);
      chk(32'(e), 32'(a > 12'h014));
   endtask : rdc

   task automatic rnd(output ots_core_t c);
      c = '0;
      r = lfsr(r);
      c[$bits(ots_core_t)-1 -: 18] = r[17:0];
      c.fault_undervoltage = c.fault_undervoltage & c.fault_any;
      c.step_sequencer_done = 1'b0;
      r = lfsr(r);
      // narrow values so equal and boundary cases come up often
      {c.set_freq, c.run_freq} = {16'(r[1:0]), 16'(r[3:2])};
      {c.upper_limit, c.lower_limit} = {16'(r[5:4]), 16'(r[7:6])};
      {c.count_value, c.set_count_target} = {16'(r[9:8]), 16'(r[11:10])};
      {c.designated_count_target, c.length} = {16'(r[13:12]), 16'(r[15:14])};
      {c.length_target, c.accumulated_run_time} = {16'(r[17:16]), 32'(r[19:18])};
      c.run_time_limit = 32'(r[21:20]);
      c.analog_input_one = 16'($signed(r[23:22]));
      c.analog_input_two = 16'($signed(r[25:24]));
      c.analog_level = 16'(lfsr(r) >> 16);
      c.pulse_half_period = 32'h0000_000a;
   endtask : rnd

   task automatic drv(input ots_core_t c);
      @(posedge core_clk);
      core_i <= c;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : drv

   task automatic end_of_test;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (30000) @(posedge core_clk);
      num_errors++;
      end_of_test();
   end

   initial begin
      ots_core_t c;
      logic      x;
      int        hi;
      logic [3:0]  v;
      logic [31:0] d;
      {psel, penable, pwrite, paddr, pwdata, pstrb, arm} = '0;
      core_i = '0;
      sys_rst = 1;
      r = 32'h2183_a1d1;
      repeat (12) @(posedge core_clk);
      sys_rst <= 0;
      for (int k = 0; k < 6; k++) rdc(12'(4 * k), rstv[k]);
      rdc(12'h020, 32'h0000_0000);
      // a write without its low byte strobe must leave the selector alone
      apb(1'b1, 12'h004, 32'h0000_0007, 4'he, d, x);
      chk(32'(x), 32'h0000_0000);
      rdc(12'h004, 32'h0000_0002);
      rnd(c);
      drv(c);
      chk({pins_o.analog_drive_en, pins_o.multi_function_pin}, 2'b10);
      chk(pins_o.analog_output, c.analog_level);
      wr(12'h000, 32'h0000_0003);
      rdc(12'h000, 32'h0000_0002);
      wr(12'h000, 32'h0000_0001);
      // codes 0 to 24, the invalid 23 and 24 too, on all four outputs at once
      for (int k = 0; k < 25; k++) begin
         for (int i = 1; i < 5; i++) wr(12'(4 * i), 32'(k));
         repeat (6) begin
            rnd(c);
            drv(c);
            x = exp_fn(k, c);
            v = {pins_o.relay, pins_o.digital_out_one, pins_o.digital_out_two,
                 pins_o.multi_function_pin};
            chk(v, {4{x}});
         end
      end
      wr(12'h004, 32'h0000_000d);
      c = '0;
      c.step_sequencer_done = 1'b1;
      @(posedge core_clk);
      core_i <= c;
      @(posedge core_clk);
      core_i.step_sequencer_done <= 1'b0;
      hi = 0;
      repeat (40) begin
         @(posedge core_clk);
         #1 hi += int'(pins_o.relay);
      end
      chk(hi, SEQ);
      // fast request is clamped by the pin's frequency ceiling
      rnd(c);
      drv(c);
      wr(12'h000, 32'h0000_0000);
      @(posedge core_clk);
      arm <= 1;
      repeat (7000) @(posedge core_clk);
      #1;
      chk(min_half, 2000);
      chk({pins_o.analog_drive_en, pins_o.analog_output}, 17'h0_0000);
      end_of_test();
   end
endmodule : tb_top
